// File: rtl/ddic_pkg.sv
package ddic_pkg;

    // Capture modes selected by the core.
    typedef enum logic [1:0] {
        DDIC_MODE_SDR  = 2'b00,
        DDIC_MODE_DDR  = 2'b01,
        DDIC_MODE_GEAR = 2'b10
    } ddic_mode_t;

    // Width of one captured word: four streams in gearbox mode.
    localparam int unsigned DDIC_WORD_W   = 4;
    // Depth of the output buffer.
    localparam int unsigned DDIC_BUF_D    = 2;
    // Bit positions of the streams inside a word.
    localparam int unsigned DDIC_POS_RISE = 0;
    localparam int unsigned DDIC_POS_FALL = 1;
    localparam int unsigned DDIC_POS_AE   = 0;
    localparam int unsigned DDIC_POS_AO   = 1;
    localparam int unsigned DDIC_POS_BE   = 2;
    localparam int unsigned DDIC_POS_BO   = 3;
    // Values after reset.
    localparam logic [3:0] DDIC_WORD_RST  = 4'h0;
    localparam logic       DDIC_POL_RST   = 1'b0;
    localparam logic       DDIC_STRB_RST  = 1'b1;

    typedef logic [DDIC_WORD_W-1:0] ddic_word_t;

    // State on the strobe-delayed link clock.
    typedef struct packed {
        ddic_mode_t mode_s1;
        ddic_mode_t mode_s2;
        logic       rise;
        logic       have_rise;
        logic       phase;
        ddic_word_t pair_hold;
        ddic_word_t word;
        logic       tog;
    } ddic_link_t;

    // State on the system clock.
    typedef struct packed {
        logic       tog_s1;
        logic       tog_s2;
        logic       tog_s3;
        logic       strb_s1;
        logic       strb_s2;
        logic       strb_s3;
        logic       sdr_s1;
        logic       sdr_s2;
        logic       armed;
        logic       pol;
        ddic_word_t buf0;
        ddic_word_t buf1;
        logic [1:0] cnt;
        logic       ovf;
        logic       out_vld;
    } ddic_sys_t;

endpackage : ddic_pkg

// File: rtl/ddic_top.sv
`timescale 1ns/1ps

module ddic_top (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              dqs_clk_i,
    input  wire logic              dqs_pin_i,
    input  wire logic              pin_data_i,
    input  wire ddic_pkg::ddic_mode_t mode_i,
    input  wire logic              read_start_i,
    input  wire logic              polarity_auto_i,
    input  wire logic              capture_clock_polarity_i,
    input  wire logic              out_ready_i,
    output logic                   out_valid_o,
    output logic                   rise_edge_stream_o,
    output logic                   fall_edge_stream_o,
    output logic                   gear_out_a_even_o,
    output logic                   gear_out_a_odd_o,
    output logic                   gear_out_b_even_o,
    output logic                   gear_out_b_odd_o,
    output logic                   polarity_o,
    output logic                   overflow_o,
    output logic                   unregistered_pin_input_o
);

    ddic_pkg::ddic_link_t lnk;
    ddic_pkg::ddic_link_t next_lnk;
    ddic_pkg::ddic_sys_t  st;
    ddic_pkg::ddic_sys_t  next_st;
    logic                 fall_q;
    ddic_pkg::ddic_word_t word_neg;
    logic                 strb_n1;
    logic                 strb_n2;

    ////////////////////////////////////////////////////////////////////////////
    // The bypass is a pure wire so the core sees the pin with no latency.
    assign unregistered_pin_input_o = pin_data_i;

    ////////////////////////////////////////////////////////////////////////////
    // Falling strobe edge sample; it lives on the link clock's other edge.
    always_ff @(negedge dqs_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            fall_q <= 1'b0;
        else
            fall_q <= pin_data_i;
    end

    // Rising edge sample and word assembly. A pair is finished at the rising
    // edge after its falling half, so the first edge after reset yields nothing and later bursts open with a stale pair.
    always_comb
    begin
        next_lnk         = lnk;
        next_lnk.mode_s1 = mode_i;
        next_lnk.mode_s2 = lnk.mode_s1;
        next_lnk.rise    = pin_data_i;
        next_lnk.have_rise = 1'b1;
        if (lnk.have_rise)
        begin
            if (lnk.mode_s2 == ddic_pkg::DDIC_MODE_DDR)
            begin
                next_lnk.word = {2'h0, fall_q, lnk.rise};
                next_lnk.tog  = ~lnk.tog;
            end
            else if (lnk.mode_s2 == ddic_pkg::DDIC_MODE_GEAR)
            begin
                // Two pairs make one word; cell A holds the older pair.
                next_lnk.phase = ~lnk.phase;
                if (lnk.phase)
                begin
                    next_lnk.word = {fall_q, lnk.rise, lnk.pair_hold[1:0]};
                    next_lnk.tog  = ~lnk.tog;
                end
                else
                    next_lnk.pair_hold = {2'h0, fall_q, lnk.rise};
            end
        end
    end

    always_ff @(posedge dqs_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            lnk <= '0;
        else
            lnk <= next_lnk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Half-cycle copies: the held word and the strobe pin seen on the falling
    // system edge. The word is stable for a whole strobe period once the toggle
    // moves, so sampling it here is safe.
    always_ff @(negedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            word_neg <= ddic_pkg::DDIC_WORD_RST;
            strb_n1  <= ddic_pkg::DDIC_STRB_RST;
            strb_n2  <= ddic_pkg::DDIC_STRB_RST;
        end
        else
        begin
            word_neg <= lnk.word;
            strb_n1  <= dqs_pin_i;
            strb_n2  <= strb_n1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System domain: synchronisers, polarity, buffer.
    always_comb
    begin
        logic       push;
        logic       pop;
        logic       fresh;
        ddic_pkg::ddic_word_t din;
        push    = 1'b0;
        pop     = 1'b0;
        fresh   = 1'b0;
        din     = ddic_pkg::DDIC_WORD_RST;
        next_st = st;
        next_st.tog_s1  = lnk.tog;
        next_st.tog_s2  = st.tog_s1;
        next_st.tog_s3  = st.tog_s2;
        next_st.strb_s1 = dqs_pin_i;
        next_st.strb_s2 = st.strb_s1;
        next_st.strb_s3 = st.strb_s2;
        next_st.sdr_s1  = pin_data_i;
        next_st.sdr_s2  = st.sdr_s1;
        next_st.ovf     = 1'b0;

        // In auto mode polarity holds until the preamble of the armed read; otherwise it follows capture_clock_polarity_i.
        if (st.armed && st.strb_s3 && !st.strb_s2)
        begin
            // If the falling-edge copy already saw low, data settles in the
            // first half of the cycle, so the falling system edge is safer.
            next_st.armed = 1'b0;
            next_st.pol   = polarity_auto_i ? !strb_n2
                                            : capture_clock_polarity_i;
        end
        else if (!polarity_auto_i)
            next_st.pol = capture_clock_polarity_i;

        // A rearm in the same cycle as a detection wins, so the new read is not lost.
        if (read_start_i)
            next_st.armed = 1'b1;

        // Pick the word source by mode.
        unique case (mode_i)
            ddic_pkg::DDIC_MODE_SDR:
            begin
                fresh = 1'b1;
                din   = {3'h0, st.sdr_s2};
            end
            ddic_pkg::DDIC_MODE_DDR,
            ddic_pkg::DDIC_MODE_GEAR:
            begin
                fresh = st.tog_s2 != st.tog_s3;
                din   = st.pol ? word_neg : lnk.word;
            end
            default:
            begin
                fresh = 1'b0;
                din   = ddic_pkg::DDIC_WORD_RST;
            end
        endcase

        // Two-entry buffer; buf0 is the head the core sees.
        pop  = (st.cnt != 2'h0) && out_ready_i;
        push = fresh && ((st.cnt != 2'h2) || pop);
        next_st.ovf = fresh && !push;
        if (pop)
        begin
            next_st.buf0 = st.buf1;
            next_st.cnt  = st.cnt - 2'h1;
        end
        if (push)
        begin
            if (next_st.cnt == 2'h0)
                next_st.buf0 = din;
            else
                next_st.buf1 = din;
            next_st.cnt = next_st.cnt + 2'h1;
        end
        // Valid is kept in its own flop so the output needs no gate after it.
        next_st.out_vld = next_st.cnt != 2'h0;
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st         <= '0;
            st.strb_s1 <= ddic_pkg::DDIC_STRB_RST;
            st.strb_s2 <= ddic_pkg::DDIC_STRB_RST;
            st.strb_s3 <= ddic_pkg::DDIC_STRB_RST;
            st.pol     <= ddic_pkg::DDIC_POL_RST;
        end
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs come straight from the state flops.
    assign out_valid_o        = st.out_vld;
    assign rise_edge_stream_o = st.buf0[ddic_pkg::DDIC_POS_RISE];
    assign fall_edge_stream_o = st.buf0[ddic_pkg::DDIC_POS_FALL];
    assign gear_out_a_even_o  = st.buf0[ddic_pkg::DDIC_POS_AE];
    assign gear_out_a_odd_o   = st.buf0[ddic_pkg::DDIC_POS_AO];
    assign gear_out_b_even_o  = st.buf0[ddic_pkg::DDIC_POS_BE];
    assign gear_out_b_odd_o   = st.buf0[ddic_pkg::DDIC_POS_BO];
    assign polarity_o         = st.pol;
    assign overflow_o         = st.ovf;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the system clock.
    sequence s_preamble_fall;
        st.armed && st.strb_s3 && !st.strb_s2;
    endsequence

    a_sdr_sample: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st.sdr_s2 == $past(pin_data_i, 2) || !$past(rst_n_i, 2))
        else $error("SDR sample is not the pin two cycles back");
    a_bypass_wire: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        unregistered_pin_input_o == pin_data_i)
        else $error("Bypass differs from pin");
    a_pol_detect: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_preamble_fall |=> st.armed == $past(read_start_i) && polarity_o == $past(polarity_auto_i ?
            !strb_n2 : capture_clock_polarity_i))
        else $error("Polarity not taken at preamble");
    a_pol_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!(st.armed && st.strb_s3 && !st.strb_s2) && polarity_auto_i) |=> $stable(polarity_o))
        else $error("Polarity moved within a burst");
    a_rearm_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        read_start_i |=> st.armed)
        else $error("Read start did not rearm detection");
    a_pol_forced: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !polarity_auto_i |=> polarity_o == $past(capture_clock_polarity_i))
        else $error("Forced polarity not applied");
    a_ddr_source: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((mode_i == ddic_pkg::DDIC_MODE_DDR || mode_i == ddic_pkg::DDIC_MODE_GEAR)
            && st.tog_s2 != st.tog_s3 && st.cnt == 2'h0)
        |=> out_valid_o && st.buf0 == $past(st.pol ? word_neg : lnk.word))
        else $error("Strobe word not re-registered");
    a_buf_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (out_valid_o && !out_ready_i) |=> out_valid_o && $stable(st.buf0))
        else $error("Head word changed while stalled");
    a_no_overrun: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st.cnt <= 2'h2 && out_valid_o == (st.cnt != 2'h0))
        else $error("Buffer count beyond depth");

endmodule : ddic_top

// File: tb/ddic_mem_model.sv
`timescale 1ns/1ps

// Memory side of a read: parks the strobe, then sends one burst of bit pairs.
module ddic_mem_model (
    output logic dqs_clk_o,
    output logic dqs_pin_o,
    output logic dq_o
);

    // The strobe rests high on its termination and the link clock stands still.
    initial
    begin
        dqs_clk_o = 1'b0;
        dqs_pin_o = 1'b1;
        dq_o      = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data moves a quarter period before each edge, as a centred strobe sees it.
    task automatic run(input logic [31:0] bits, input int npairs);
        int i;
        // A random sub-cycle offset keeps the strobe unrelated in phase to the
        // system clock; auto detection still picks the falling-edge copy (polarity 1) at every offset.
        #(($urandom % 50) * 0.1 + 0.05);
        dqs_pin_o = 1'b0;
        #160;
        for (i = 0; i <= 2 * npairs; i++)
        begin
            dq_o = bits[i % 32];
            #40 dqs_clk_o = ~dqs_clk_o;
            dqs_pin_o = dqs_clk_o;
            #40;
        end
        dqs_clk_o = 1'b0;
        dqs_pin_o = 1'b1;
        #20;
        dq_o      = ~dq_o; // A released line must not keep showing the last bit.
    endtask : run

endmodule : ddic_mem_model

// File: tb/ddr_input_capture_polarity_test.sv
`timescale 1ns/1ps

// Random and corner-case run of the capture path against the memory model.
module ddr_input_capture_polarity_test;

    logic                 clock_i, rst_n_i, rd_go, pol_auto, cap_pol, rdy, sdr_pin;
    logic                 use_mem, rnd_rdy, dqs_clk, dqs_pin, mem_dq, seen;
    logic                 vld, rise_s, fall_s, ae, ao, be, bo, pol, ovf, byp;
    logic [31:0]          b;
    ddic_pkg::ddic_mode_t mode;
    ddic_pkg::ddic_word_t got[$];
    int                   n_mismatch = 0;
    int                   checks_done = 0;
    int                   k;

    ////////////////////////////////////////////////////////////////////////////////
    // The two clocks are unrelated; the link clock comes from the model.
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    ddic_mem_model mem_u (.dqs_clk_o(dqs_clk), .dqs_pin_o(dqs_pin), .dq_o(mem_dq));

    ddic_top dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .dqs_clk_i(dqs_clk), .dqs_pin_i(dqs_pin),
        .pin_data_i(use_mem ? mem_dq : sdr_pin), .mode_i(mode), .read_start_i(rd_go),
        .polarity_auto_i(pol_auto), .capture_clock_polarity_i(cap_pol),
        .out_ready_i(rdy), .out_valid_o(vld), .rise_edge_stream_o(rise_s),
        .fall_edge_stream_o(fall_s), .gear_out_a_even_o(ae), .gear_out_a_odd_o(ao),
        .gear_out_b_even_o(be), .gear_out_b_odd_o(bo), .polarity_o(pol),
        .overflow_o(ovf), .unregistered_pin_input_o(byp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Collect every popped word; the core stalls at random while enabled.
    always @(posedge clock_i)
        if (vld === 1'b1 && rdy === 1'b1)
            got.push_back(mode == ddic_pkg::DDIC_MODE_GEAR ? {bo, be, ao, ae}
                                                            : {2'b00, fall_s, rise_s});

    always @(negedge clock_i)
        if (rnd_rdy)
            rdy <= 1'($urandom);

    task automatic check(input ddic_pkg::ddic_word_t seen_v, input ddic_pkg::ddic_word_t exp);
        checks_done++;
        if (seen_v !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen_v, exp);
        end
    endtask : check

    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // Expected words, worked out from the bits the memory sends.
    function automatic ddic_pkg::ddic_word_t exp_pair(input logic [31:0] v, input int k);
        return {2'b00, v[2*k+1], v[2*k]};
    endfunction : exp_pair

    // A burst opens with a stale pair, so gearbox word j holds pairs 2j-1 and 2j.
    function automatic ddic_pkg::ddic_word_t exp_gear(input logic [31:0] v, input int j);
        return v[4*j-2 +: 4];
    endfunction : exp_gear

    // One read: arm, let the memory send, and see that polarity holds.
    task automatic burst(input int n);
        logic p;
        @(negedge clock_i) rd_go = 1'b1;
        @(negedge clock_i) rd_go = 1'b0;
        fork
            mem_u.run(b, n);
            begin
                repeat (48) @(negedge clock_i);
                p = pol;
            end
        join
        repeat (40) @(negedge clock_i);
        check({3'h0, pol}, {3'h0, p});
    endtask : burst

    ////////////////////////////////////////////////////////////////////////////////
    // A hang counts as a mismatch and ends the run the usual way.
    initial
    begin
        #200000;
        n_mismatch++;
        close_out();
    end

    initial
    begin
        void'($urandom(76460));
        {rst_n_i, rd_go, pol_auto, cap_pol, rdy, sdr_pin, use_mem, rnd_rdy} = 8'h08;
        mode = ddic_pkg::DDIC_MODE_SDR;
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'b1;
        check({2'h0, vld, pol}, 4'h0);
        for (k = 0; k < 4; k++)
        begin
            @(negedge clock_i) sdr_pin = 1'($urandom);
            #1 check({3'h0, byp}, {3'h0, sdr_pin});
        end
        for (k = 1; k >= 0; k--)
        begin
            cap_pol = 1'(k);
            repeat (3) @(negedge clock_i);
            check({3'h0, pol}, {3'h0, cap_pol});
        end
        for (k = 0; k < 4; k++)
        begin
            sdr_pin = 1'($urandom);
            repeat (8) @(negedge clock_i);
            check({2'h0, vld, rise_s}, {2'h1, sdr_pin});
        end
        // A stalled core fills both entries, then every further word is dropped and overflow stays high.
        rdy = 1'b0;
        seen = 1'b0;
        repeat (8) @(negedge clock_i) seen |= ovf;
        check({2'h0, vld, seen}, 4'h3);
        mode = ddic_pkg::ddic_mode_t'(2'b11);
        rdy = 1'b1;
        repeat (6) @(negedge clock_i);
        check({3'h0, vld}, 4'h0);
        // Warm-up bursts let the mode settle on the link clock.
        mode = ddic_pkg::DDIC_MODE_DDR;
        {use_mem, rnd_rdy, pol_auto} = 3'h7;
        b = $urandom;
        burst(3);
        got.delete();
        burst(6);
        check({3'h0, got.size() >= 6}, 4'h1);
        for (k = 0; k < 6; k++)
            check(got[got.size() - 6 + k], exp_pair(b, k));
        mode = ddic_pkg::DDIC_MODE_GEAR;
        b = $urandom;
        burst(3);
        for (k = 0; k < 16; k++)
            b[k] = b[16 + ((k / 2) % 2) * 2 + k % 2];
        got.delete();
        burst(6);
        check({3'h0, got.size() == 3}, 4'h1);
        for (k = 1; k < 3; k++)
            check(got[k], exp_gear(b, k));
        close_out();
    end

endmodule : ddr_input_capture_polarity_test
